/* hdl/imss_slot.sv */
// Downstream port slot of the interconnect: gating, limits, FIFOs, slices
// How it works
// - Default to synchronous when the measured port clock period is k core clock cycles, k up to 16.
// - Clock-relation bit: 0 synchronous port clock, 1 independent, needing crossing.
// - Synchronous ports use a configured 31-bit frequency ratio to the core clock.
// - Write-support bit 1 enables AW, W, B channels; 0 makes port read-only.
// - Read-support bit 1 enables AR and R channels; 0 makes port write-only.
// - Outstanding data-active writes are capped at an issuing limit of 1 to 32.
// - Outstanding active reads are capped at an issuing limit of 1 to 32.
// - Secure-slave bit decides whether non-secure accesses (prot bit 1 set) may reach the port.
// - Without narrow tolerance, multi-beat bursts must use full data width size.
// - Optional write data FIFO after write routing: depth 0, 32 or 512.
// - Packet write mode holds write address until the whole burst is buffered.
// - Optional read data FIFO before read arbitration: depth 0, 32 or 512.
// - Packet read mode holds read address until the FIFO can take the burst.
// - Each channel gets a stage by code: 0 bypass, 1 full, 7 light, 8 auto.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module imss_slot
  import imss_pkg::*;
#(
  parameter imss_pkg::imss_slice_e write_addr_slice_select = imss_pkg::SLICE_BYPASS,
  parameter imss_pkg::imss_slice_e w_data_slice_select = imss_pkg::SLICE_BYPASS,
  parameter imss_pkg::imss_slice_e b_resp_slice_select = imss_pkg::SLICE_BYPASS,
  parameter imss_pkg::imss_slice_e read_addr_slice_select = imss_pkg::SLICE_BYPASS,
  parameter imss_pkg::imss_slice_e r_data_slice_select = imss_pkg::SLICE_BYPASS,
  parameter int write_fifo_depth = imss_pkg::FIFO_NONE,
  parameter int read_fifo_depth = imss_pkg::FIFO_NONE
) (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic s_awvalid, // Register bus write address valid
  output logic s_awready, // Register bus write address ready
  input wire logic [7:0] s_awaddr, // Register byte address
  input wire logic s_wvalid, // Register write data valid
  output logic s_wready, // Register write data ready
  input wire logic [31:0] s_wdata, // Register write data
  input wire logic [3:0] s_wstrb, // Register byte enables
  output logic s_bvalid, // Register write response valid
  input wire logic s_bready, // Register write response ready
  output logic [1:0] s_bresp, // Register write response
  input wire logic s_arvalid, // Register read address valid
  output logic s_arready, // Register read address ready
  input wire logic [7:0] s_araddr, // Register read byte address
  output logic s_rvalid, // Register read data valid
  input wire logic s_rready, // Register read data ready
  output logic [31:0] s_rdata, // Register read data
  output logic [1:0] s_rresp, // Register read response
  input wire logic port_clk_in, // Downstream port clock, sampled
  output logic port_clock_is_independent, // Port clock needs crossing
  input wire logic c_awvalid, // Routed write address valid
  output logic c_awready, // Routed write address ready
  input wire logic [AX_W-1:0] c_aw, // Routed {addr,len,size,burst,prot}
  input wire logic c_wvalid, // Routed write data valid
  output logic c_wready, // Routed write data ready
  input wire logic [WP_W-1:0] c_w, // Routed {data,strb,last}
  output logic c_bvalid, // Routed write response valid
  input wire logic c_bready, // Routed write response ready
  output logic [BP_W-1:0] c_bresp, // Routed write response
  input wire logic c_arvalid, // Routed read address valid
  output logic c_arready, // Routed read address ready
  input wire logic [AX_W-1:0] c_ar, // Routed {addr,len,size,burst,prot}
  output logic c_rvalid, // Routed read data valid
  input wire logic c_rready, // Routed read data ready
  output logic [RP_W-1:0] c_r, // Routed {data,resp,last}
  output logic d_awvalid, // Downstream write address valid
  input wire logic d_awready, // Downstream write address ready
  output logic [AX_W-1:0] d_aw, // Downstream {addr,len,size,burst,prot}
  output logic d_wvalid, // Downstream write data valid
  input wire logic d_wready, // Downstream write data ready
  output logic [WP_W-1:0] d_w, // Downstream {data,strb,last}
  input wire logic d_bvalid, // Downstream write response valid
  output logic d_bready, // Downstream write response ready
  input wire logic [BP_W-1:0] d_bresp, // Downstream write response
  output logic d_arvalid, // Downstream read address valid
  input wire logic d_arready, // Downstream read address ready
  output logic [AX_W-1:0] d_ar, // Downstream {addr,len,size,burst,prot}
  input wire logic d_rvalid, // Downstream read data valid
  output logic d_rready, // Downstream read data ready
  input wire logic [RP_W-1:0] d_r // Downstream {data,resp,last}
);
  import imss_pkg::*;

  localparam int W_DEPTH = write_fifo_depth != 0 ? write_fifo_depth : imss_slice_depth(w_data_slice_select);
  localparam int R_DEPTH = read_fifo_depth != 0 ? read_fifo_depth : imss_slice_depth(r_data_slice_select);
  if ((write_fifo_depth != FIFO_NONE && write_fifo_depth != FIFO_SMALL && write_fifo_depth != FIFO_PACKET) ||
      (read_fifo_depth != FIFO_NONE && read_fifo_depth != FIFO_SMALL && read_fifo_depth != FIFO_PACKET)) begin : g_bad
    $error("imss_slot: FIFO depth must be 0, 32 or 512");
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Register bus slave
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] ctrl_r;
  logic [5:0] wlim_r, rlim_r;
  logic [30:0] ratio_r;
  logic [1:0] flags_r;
  logic [CNT_W-1:0] wr_cnt_r, rd_cnt_r;
  logic [LVL_W-1:0] wb_cnt_r;
  logic [RSV_W-1:0] rsv_r;
  logic [7:0] per_cnt_r, per_meas_r;
  logic p_s1_r, p_s2_r, p_s3_r, p_lvl_r, indep_r;

  assign s_awready = !aw_have_r && !bvalid_r;
  assign s_wready = !w_have_r && !bvalid_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rvalid_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;

  wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
  wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire wr_ctrl = wr_fire && waddr_r == REG_CTRL;
  wire wr_issue = wr_fire && waddr_r == REG_ISSUE;
  wire wr_ratio = wr_fire && waddr_r == REG_RATIO;
  wire wr_flags = wr_fire && waddr_r == REG_FLAGS;
  wire wr_hit = wr_ctrl || wr_issue || wr_ratio || wr_flags || waddr_r == REG_STATUS;
  wire [31:0] issue_word = {18'h00000, rlim_r, 2'h0, wlim_r};
  wire [31:0] ctrl_new = ({24'h000000, ctrl_r} & ~bmask) | (wdata_r & bmask);
  wire [31:0] issue_new = (issue_word & ~bmask) | (wdata_r & bmask);
  wire [31:0] ratio_new = ({1'b0, ratio_r} & ~bmask) | (wdata_r & bmask);
  // Synchronous port: configured ratio agrees with the measured period, shown in STATUS bit 17
  wire ratio_match = !indep_r && ratio_r == {23'h000000, per_meas_r};
  wire [31:0] status_word = {4'h0, per_meas_r, 2'h0, ratio_match, indep_r, 2'h0, rd_cnt_r, 2'h0, wr_cnt_r};
  wire ar_take = s_arvalid && s_arready;
  wire rd_hit = s_araddr == REG_CTRL || s_araddr == REG_ISSUE || s_araddr == REG_RATIO ||
                s_araddr == REG_STATUS || s_araddr == REG_FLAGS;
  wire [31:0] rd_word = s_araddr == REG_CTRL ? {24'h000000, ctrl_r} :
                        s_araddr == REG_ISSUE ? issue_word :
                        s_araddr == REG_RATIO ? {1'b0, ratio_r} :
                        s_araddr == REG_STATUS ? status_word :
                        s_araddr == REG_FLAGS ? {30'h00000000, flags_r} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        waddr_r <= s_awaddr;
      end else if (wr_fire) aw_have_r <= 1'b0;
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end else if (wr_fire) w_have_r <= 1'b0;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) bvalid_r <= 1'b0;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) rvalid_r <= 1'b0;
    end
  end

  // Configuration registers
  wire [5:0] wlim = wlim_r == 6'h00 ? 6'(ISSUE_MIN) : (wlim_r > 6'(ISSUE_MAX) ? 6'(ISSUE_MAX) : wlim_r);
  wire [5:0] rlim = rlim_r == 6'h00 ? 6'(ISSUE_MIN) : (rlim_r > 6'(ISSUE_MAX) ? 6'(ISSUE_MAX) : rlim_r);
  wire write_en = ctrl_r[CTRL_WR_EN];
  wire read_en = ctrl_r[CTRL_RD_EN];
  wire secure = ctrl_r[CTRL_SECURE];
  wire narrow_ok = ctrl_r[CTRL_NARROW_OK];
  wire pkt_w_act = ctrl_r[CTRL_PKT_WR] && write_fifo_depth == FIFO_PACKET;
  wire pkt_r_act = ctrl_r[CTRL_PKT_RD] && read_fifo_depth == FIFO_PACKET;
  logic sec_refuse_seen, narrow_refuse_seen;
  wire [1:0] flags_set = {narrow_refuse_seen, sec_refuse_seen};
  wire [1:0] flags_clr = wr_flags ? (wdata_r[1:0] & bmask[1:0]) : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      wlim_r <= LIMIT_RST;
      rlim_r <= LIMIT_RST;
      ratio_r <= RATIO_RST;
      flags_r <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_new[7:0];
      if (wr_issue) wlim_r <= issue_new[5:0];
      if (wr_issue) rlim_r <= issue_new[ISSUE_RD_LSB+5:ISSUE_RD_LSB];
      if (wr_ratio) ratio_r <= ratio_new[30:0];
      flags_r <= (flags_r & ~flags_clr) | flags_set;
    end
  end

  // Port clock sampling, period measure and clock relation
  wire p_agree = p_s2_r == p_s3_r;
  wire p_rise = p_agree && p_s3_r && !p_lvl_r;
  wire meas_sync = per_meas_r != 8'h00 && per_meas_r <= 8'(SYNC_K_MAX);
  wire indep_nxt = ctrl_r[CTRL_INDEP_OVR] ? ctrl_r[CTRL_INDEP_VAL] : !meas_sync;
  assign port_clock_is_independent = indep_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_s1_r <= 1'b0;
      p_s2_r <= 1'b0;
      p_s3_r <= 1'b0;
      p_lvl_r <= 1'b0;
      per_cnt_r <= 8'h00;
      per_meas_r <= 8'h00;
      indep_r <= 1'b1;
    end else begin
      p_s1_r <= port_clk_in;
      p_s2_r <= p_s1_r;
      p_s3_r <= p_s2_r;
      if (p_agree) p_lvl_r <= p_s3_r;
      if (p_rise) per_cnt_r <= 8'h01;
      else if (per_cnt_r != 8'hFF) per_cnt_r <= per_cnt_r + 8'h01;
      if (p_rise) per_meas_r <= per_cnt_r;
      else if (per_cnt_r == 8'hFF) per_meas_r <= 8'hFF;
      indep_r <= indep_nxt;
    end
  end
  // Channel stages
  logic s_awv, s_awr, s_wv, s_wr, s_arv, s_arr, w_in_rdy;
  logic [AX_W-1:0] s_aw, s_ar;
  logic [LVL_W-1:0] r_level;
  imss_stage #(.W(AX_W), .DEPTH(imss_slice_depth(write_addr_slice_select)), .LW(LVL_W)) u_aw (
    .clk(aclk), .rst_n(aresetn), .in_valid(c_awvalid), .in_ready(c_awready), .in_data(c_aw),
    .out_valid(s_awv), .out_ready(s_awr), .out_data(s_aw), .level());
  imss_stage #(.W(WP_W), .DEPTH(W_DEPTH), .LW(LVL_W)) u_w (
    .clk(aclk), .rst_n(aresetn), .in_valid(c_wvalid && write_en), .in_ready(w_in_rdy), .in_data(c_w),
    .out_valid(s_wv), .out_ready(s_wr), .out_data(d_w), .level());
  imss_stage #(.W(BP_W), .DEPTH(imss_slice_depth(b_resp_slice_select)), .LW(LVL_W)) u_b (
    .clk(aclk), .rst_n(aresetn), .in_valid(d_bvalid), .in_ready(d_bready), .in_data(d_bresp),
    .out_valid(c_bvalid), .out_ready(c_bready), .out_data(c_bresp), .level());
  imss_stage #(.W(AX_W), .DEPTH(imss_slice_depth(read_addr_slice_select)), .LW(LVL_W)) u_ar (
    .clk(aclk), .rst_n(aresetn), .in_valid(c_arvalid), .in_ready(c_arready), .in_data(c_ar),
    .out_valid(s_arv), .out_ready(s_arr), .out_data(s_ar), .level());
  imss_stage #(.W(RP_W), .DEPTH(R_DEPTH), .LW(LVL_W)) u_r (
    .clk(aclk), .rst_n(aresetn), .in_valid(d_rvalid), .in_ready(d_rready), .in_data(d_r),
    .out_valid(c_rvalid), .out_ready(c_rready), .out_data(c_r), .level(r_level));
  assign c_wready = w_in_rdy && write_en;

  // Address gating: enables, limits, security, narrow bursts, packet modes
  wire aw_sec_bad = secure && s_aw[1];
  wire ar_sec_bad = secure && s_ar[1];
  wire aw_nar_bad = !narrow_ok && s_aw[15:8] != 8'h00 && s_aw[7:5] != SIZE_FULL;
  wire ar_nar_bad = !narrow_ok && s_ar[15:8] != 8'h00 && s_ar[7:5] != SIZE_FULL;
  wire [RSV_W-1:0] ar_need = {6'h00, s_ar[15:8]} + 14'h0001;
  wire ar_room = {4'h0, r_level} + rsv_r + ar_need <= RSV_W'(read_fifo_depth);
  wire aw_go = write_en && wr_cnt_r < wlim && !aw_sec_bad && !aw_nar_bad &&
               (!pkt_w_act || wb_cnt_r != '0);
  wire ar_go = read_en && rd_cnt_r < rlim && !ar_sec_bad && !ar_nar_bad &&
               (!pkt_r_act || ar_room);
  assign d_awvalid = s_awv && aw_go;
  assign s_awr = d_awready && aw_go;
  assign d_aw = s_aw;
  assign d_wvalid = s_wv && write_en;
  assign s_wr = d_wready && write_en;
  assign d_arvalid = s_arv && ar_go;
  assign s_arr = d_arready && ar_go;
  assign d_ar = s_ar;
  assign sec_refuse_seen = (s_awv && aw_sec_bad) || (s_arv && ar_sec_bad);
  assign narrow_refuse_seen = (s_awv && aw_nar_bad) || (s_arv && ar_nar_bad);

  wire aw_hs = d_awvalid && d_awready;
  wire ar_hs = d_arvalid && d_arready;
  wire b_hs = d_bvalid && d_bready;
  wire r_hs = d_rvalid && d_rready;
  wire rlast_hs = r_hs && d_r[0];
  wire wlast_in = c_wvalid && c_wready && c_w[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt_r <= '0;
      rd_cnt_r <= '0;
      wb_cnt_r <= '0;
      rsv_r <= '0;
    end else begin
      wr_cnt_r <= wr_cnt_r + CNT_W'(aw_hs) - CNT_W'(b_hs);
      rd_cnt_r <= rd_cnt_r + CNT_W'(ar_hs) - CNT_W'(rlast_hs);
      wb_cnt_r <= wb_cnt_r + LVL_W'(wlast_in) - LVL_W'(aw_hs && wb_cnt_r != '0);
      rsv_r <= rsv_r + (ar_hs ? ar_need : '0) - RSV_W'(r_hs && rsv_r != '0);
    end
  end

  wr_limit_a: assert property (wr_cnt_r <= wlim) else $error("write issuing limit exceeded");
  rd_limit_a: assert property (rd_cnt_r <= rlim) else $error("read issuing limit exceeded");
  read_only_a: assert property (!write_en |-> !d_awvalid && !d_wvalid) else $error("write on read-only port");
  write_only_a: assert property (!read_en |-> !d_arvalid) else $error("read on write-only port");
  secure_gate_a: assert property (secure && d_awvalid |-> !d_aw[1]) else $error("refused access issued");
  narrow_gate_a: assert property (!narrow_ok && d_arvalid && d_ar[15:8] != 8'h00 |-> d_ar[7:5] == SIZE_FULL)
    else $error("narrow burst issued");
  pkt_write_a: assert property (pkt_w_act && d_awvalid |-> wb_cnt_r != '0) else $error("address before burst");
  pkt_read_a: assert property (pkt_r_act && d_arvalid |-> ar_room) else $error("read issued without room");
  clock_rel_a: assert property (!ctrl_r[CTRL_INDEP_OVR] && per_meas_r == 8'h08 && $stable(ctrl_r)
    |=> !port_clock_is_independent) else $error("ratio 8 not synchronous");
  ovr_rel_a: assert property (ctrl_r[CTRL_INDEP_OVR] ##1 ctrl_r[CTRL_INDEP_OVR]
    |-> port_clock_is_independent == $past(ctrl_r[CTRL_INDEP_VAL])) else $error("override ignored");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid) else $error("write answer dropped");
endmodule
`default_nettype wire

/* shared/imss_pkg.sv */
// Shared constants and types for the downstream port slot
package imss_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int LEN_W = 8;
  localparam int AX_W = 48;
  localparam int WP_W = 37;
  localparam int RP_W = 35;
  localparam int BP_W = 2;
  localparam int LVL_W = 10;
  localparam int CNT_W = 6;
  localparam int RSV_W = 14;
  localparam logic [2:0] SIZE_FULL = 3'h2;
  localparam int ISSUE_MIN = 1;
  localparam int ISSUE_MAX = 32;
  localparam int FIFO_NONE = 0;
  localparam int FIFO_SMALL = 32;
  localparam int FIFO_PACKET = 512;
  localparam int SYNC_K_MAX = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ISSUE = 8'h04;
  localparam logic [7:0] REG_RATIO = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam int CTRL_WR_EN = 0;
  localparam int CTRL_RD_EN = 1;
  localparam int CTRL_SECURE = 2;
  localparam int CTRL_NARROW_OK = 3;
  localparam int CTRL_PKT_WR = 4;
  localparam int CTRL_PKT_RD = 5;
  localparam int CTRL_INDEP_OVR = 6;
  localparam int CTRL_INDEP_VAL = 7;
  localparam logic [7:0] CTRL_RST = 8'h0B;
  localparam int ISSUE_RD_LSB = 8;
  localparam logic [5:0] LIMIT_RST = 6'h01;
  localparam logic [30:0] RATIO_RST = 31'h00000001;
  localparam int FLAG_SECURE = 0;
  localparam int FLAG_NARROW = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    SLICE_BYPASS = 4'h0,
    SLICE_FULL = 4'h1,
    SLICE_LIGHT = 4'h7,
    SLICE_AUTO = 4'h8
  } imss_slice_e;
  function automatic int imss_slice_depth(imss_slice_e code);
    case (code)
      SLICE_FULL, SLICE_AUTO: return 2;
      SLICE_LIGHT: return 1;
      default: return 0;
    endcase
  endfunction
endpackage

/* hdl/imss_stage.sv */
// Channel stage: bypass, register slice or data FIFO of parameter depth
`timescale 1ns/100ps
`default_nettype none
module imss_stage #(
  parameter int W = 8,
  parameter int DEPTH = 2,
  parameter int LW = 10
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic in_valid, // Source valid
  output logic in_ready, // Source ready
  input wire logic [W-1:0] in_data, // Source payload
  output logic out_valid, // Sink valid
  input wire logic out_ready, // Sink ready
  output logic [W-1:0] out_data, // Sink payload
  output logic [LW-1:0] level // Entries held
);
  if (DEPTH < 0 || LW < $clog2(DEPTH + 1)) begin : g_bad
    $error("imss_stage: depth not servable");
  end
  if (DEPTH == 0) begin : g_bypass
    assign in_ready = out_ready;
    assign out_valid = in_valid;
    assign out_data = in_data;
    assign level = '0;
  end else begin : g_store
    localparam int PW = DEPTH > 1 ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, rp_r;
    logic [LW-1:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_r != LW'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        wp_r <= '0;
        rp_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        if (pop) rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        cnt_r <= cnt_r + LW'(push) - LW'(pop);
      end
    end
    always_ff @(posedge clk) begin
      if (push) mem_r[wp_r] <= in_data;
    end
    stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("stage output changed while stalled");
    no_overrun_a: assert property (@(posedge clk) disable iff (!rst_n)
      push |-> cnt_r < LW'(DEPTH))
      else $error("stage accepted while full");
  end
endmodule
`default_nettype wire

/* sim/imss_slave_model.sv */
// Downstream slave model with random stalls
`timescale 1ns/100ps
`default_nettype none
module imss_slave_model
  import imss_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic awvalid, // AW valid
  output logic awready, // AW ready
  input wire logic wvalid, // W valid
  output logic wready, // W ready
  input wire logic [WP_W-1:0] w, // W payload
  output logic bvalid, // B valid
  input wire logic bready, // B ready
  output logic [BP_W-1:0] bresp, // B payload
  input wire logic arvalid, // AR valid
  output logic arready, // AR ready
  input wire logic [AX_W-1:0] ar, // AR payload
  output logic rvalid, // R valid
  input wire logic rready, // R ready
  output logic [RP_W-1:0] r // R payload
);
  int seed = 7;
  int na, nw, bt;
  logic [AX_W-1:0] q[$];
  always @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, arready, bvalid, rvalid} <= '0;
      na = 0;
      nw = 0;
      bt = 0;
      q.delete();
    end else begin
      awready <= 1'($random(seed));
      wready <= 1'($random(seed));
      arready <= 1'($random(seed));
      na += int'(awvalid && awready);
      nw += int'(wvalid && wready && w[0]);
      if (arvalid && arready) q.push_back(ar);
      // Released payloads flip so stale values never look valid
      if (!(bvalid && !bready)) begin
        bvalid <= na > 0 && nw > 0;
        bresp <= (na > 0 && nw > 0) ? RESP_OKAY : ~bresp;
        if (na > 0 && nw > 0) begin
          na--;
          nw--;
        end
      end
      if (!(rvalid && !rready)) begin
        rvalid <= q.size() > 0;
        r <= ~r;
        if (q.size() > 0) begin
          r <= {q[0][47:16] + 32'(bt), RESP_OKAY, bt == q[0][15:8]};
          bt = (bt == q[0][15:8]) ? 0 : bt + 1;
          if (bt == 0) q.pop_front();
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Bench for the downstream port slot
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  import imss_pkg::*;
  logic aclk = 0, aresetn = 0, port_clk_in = 0, port_clock_is_independent, s_awready, s_wready, s_bvalid, s_arready;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0, s_rvalid, c_awready, c_wready;
  logic c_awvalid = 0, c_wvalid = 0, c_bready = 1, c_arvalid = 0, c_rready = 1, c_bvalid, c_arready, c_rvalid;
  logic d_awvalid, d_awready, d_wvalid, d_wready, d_bvalid, d_bready, d_arvalid, d_arready, d_rvalid, d_rready;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, rd, a;
  logic [3:0] s_wstrb = 0;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [AX_W-1:0] c_aw = 0, c_ar = 0, d_aw, d_ar;
  logic [WP_W-1:0] c_w = 0, d_w;
  logic [RP_W-1:0] c_r, d_r;
  logic [BP_W-1:0] c_bresp, d_bresp;
  int error_cnt = 0, checks = 0, seed = 96;
  logic [7:0] ra[4] = '{REG_CTRL, REG_ISSUE, REG_RATIO, 8'h20};
  logic [31:0] rv[4] = '{32'h0B, 32'h101, 32'h1, 32'h0};
  logic [AX_W-1:0] fx[2] = '{{32'h100, 8'h1, 3'h2, 5'h0A}, {32'h100, 8'h1, 3'h1, 5'h08}};
  logic [31:0] fc[2] = '{32'h0F, 32'h03}, fl[2] = '{32'h1, 32'h2};
  imss_slot #(.write_addr_slice_select(SLICE_AUTO), .w_data_slice_select(SLICE_FULL),
    .b_resp_slice_select(SLICE_FULL), .r_data_slice_select(SLICE_LIGHT), .write_fifo_depth(FIFO_SMALL))
    i_imss_slot (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata, .s_wstrb,
    .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp,
    .port_clk_in, .port_clock_is_independent, .c_awvalid, .c_awready, .c_aw, .c_wvalid, .c_wready, .c_w,
    .c_bvalid, .c_bready, .c_bresp, .c_arvalid, .c_arready, .c_ar, .c_rvalid, .c_rready, .c_r, .d_awvalid,
    .d_awready, .d_aw, .d_wvalid, .d_wready, .d_w, .d_bvalid, .d_bready, .d_bresp, .d_arvalid, .d_arready,
    .d_ar, .d_rvalid, .d_rready, .d_r);
  imss_slave_model i_imss_slave_model (.aclk, .aresetn, .awvalid(d_awvalid), .awready(d_awready),
    .wvalid(d_wvalid), .wready(d_wready), .w(d_w), .bvalid(d_bvalid), .bready(d_bready), .bresp(d_bresp),
    .arvalid(d_arvalid), .arready(d_arready), .ar(d_ar), .rvalid(d_rvalid), .rready(d_rready), .r(d_r));
  function automatic logic [RP_W-1:0] exp_r(logic [31:0] ad, int i, int n);
    return {ad + i, RESP_OKAY, i == n};
  endfunction
  task automatic lw(input logic [7:0] ad, input logic [31:0] d);
    bit ka = 0, kw = 0;
    @(posedge aclk);
    {s_awvalid, s_wvalid, s_awaddr, s_wdata, s_wstrb} <= {2'h3, ad, d, 4'hF};
    while (!(ka && kw)) begin
      @(posedge aclk);
      if (s_awready && !ka) begin ka = 1; s_awvalid <= 0; end
      if (s_wready && !kw) begin kw = 1; s_wvalid <= 0; end
    end
    s_bready <= 1;
    do @(posedge aclk); while (!s_bvalid);
    rr = s_bresp;
    s_bready <= 0;
  endtask
  task automatic lr(input logic [7:0] ad);
    @(posedge aclk);
    {s_arvalid, s_araddr, s_rready} <= {1'b1, ad, 1'b1};
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 0;
    do @(posedge aclk); while (!s_rvalid);
    {rd, rr} = {s_rdata, s_rresp};
    s_rready <= 0;
  endtask
  task automatic cw(input logic [31:0] ad, input logic [7:0] n);
    @(posedge aclk);
    {c_awvalid, c_aw} <= {1'b1, ad, n, SIZE_FULL, 5'h08};
    do @(posedge aclk); while (!c_awready);
    c_awvalid <= 0;
    for (int i = 0; i <= n; i++) begin
      {c_wvalid, c_w} <= {1'b1, ad + i, 4'hF, i == n};
      do @(posedge aclk); while (!c_wready);
    end
    c_wvalid <= 0;
    do @(posedge aclk); while (!c_bvalid);
    `CHK("bresp", RESP_OKAY, c_bresp)
  endtask
  task automatic cr(input logic [31:0] ad, input logic [7:0] n);
    @(posedge aclk);
    {c_arvalid, c_ar} <= {1'b1, ad, n, SIZE_FULL, 5'h08};
    do @(posedge aclk); while (!c_arready);
    c_arvalid <= 0;
    for (int i = 0; i <= n; i++) begin
      do @(posedge aclk); while (!c_rvalid);
      `CHK("rbeat", exp_r(ad, i, n), c_r)
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #10 aclk = ~aclk;
  initial begin #3; forever #80 port_clk_in = ~port_clk_in; end
  initial begin #400000; error_cnt++; wrap_up(); end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    foreach (ra[k]) begin
      lr(ra[k]);
      `CHK("reg", rv[k], rd)
      `CHK("resp", (k == 3) ? RESP_SLVERR : RESP_OKAY, rr)
    end
    lw(REG_RATIO, 32'h8);
    `CHK("wresp", RESP_OKAY, rr)
    repeat (60) @(posedge aclk);
    lr(REG_STATUS);
    `CHK("indep", 1'b0, rd[16])
    `CHK("ratio", 1'b1, rd[17])
    `CHK("period", 8'h08, rd[27:20])
    lw(REG_CTRL, 32'hCB);
    repeat (4) @(posedge aclk);
    `CHK("indep pin", 1'b1, port_clock_is_independent)
    a = {$random(seed)} % 32 + 1;
    lw(REG_ISSUE, a | a << 8);
    lr(REG_ISSUE);
    `CHK("issue", a | a << 8, rd)
    $display("register test done");
    repeat (8) begin
      a = $random(seed);
      cw(a, 8'($random(seed) & 3));
      cr(a, 8'($random(seed) & 3));
    end
    $display("traffic test done");
    foreach (fc[k]) begin
      lw(REG_CTRL, fc[k]);
      {c_arvalid, c_ar} <= {1'b1, fx[k]};
      repeat (16) @(posedge aclk);
      `CHK("held", 1'b0, c_arready | d_arvalid)
      lr(REG_FLAGS);
      `CHK("flags", fl[k], rd)
      {aresetn, c_arvalid} <= 2'b00;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      $display("refusal case %0d done", k);
    end
    lw(REG_CTRL, 32'h0A);
    {c_wvalid, c_w} <= {1'b1, 37'h1};
    repeat (8) @(posedge aclk);
    `CHK("w held", 1'b0, c_wready | d_wvalid)
    $display("write disable test done");
    wrap_up();
  end
endmodule
`default_nettype wire
